// File: hw/pixel_port_pkg.sv
// Constants and types shared by the pixel port formatter files
package pixel_port_pkg;
   // Register map, byte addresses
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] RXCNT_OFFSET  = 8'h08;
   // Control field positions
   localparam int FMT_LSB    = 0;
   localparam int INMODE_LSB = 4;
   localparam int DESEL_BIT  = 6;
   localparam int ENABLE_BIT = 7;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Status field positions
   localparam int ST_PHASE_BIT = 0;
   localparam int ST_CLK_BIT   = 1;
   localparam int ST_FMT_LSB   = 4;
   // Pixel clock timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int PIX_HALF_NS   = 100;
   localparam int PIX_HALF_CYC  =
      (PIX_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] HALF_LAST = 8'(PIX_HALF_CYC - 1);
   // Port geometry
   localparam int PIN_W  = 41;
   localparam int LINK_W = PIN_W + 3;
   typedef enum logic [2:0] {FMT_SDR16, FMT_SDR20, FMT_SDR24, FMT_SDR30,
                             FMT_DDR8, FMT_DDR10, FMT_DDR12} out_fmt_e;
   typedef enum logic [1:0] {IN_NONE, IN_TUNER, IN_RX24, IN_RX16}
      in_mode_e;
   typedef enum logic {PH_FIRST, PH_SECOND} phase_e;
endpackage

// File: hw/rx_link_sampler.sv
// Synchroniser and capture for the receiver link pins
`timescale 1ns/1ps
module rx_link_sampler
   import pixel_port_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  wire logic                linkClk,
   input  wire logic [LINK_W-1:0]   linkData,
   output logic      [LINK_W-1:0]   capData,
   output logic                     capValid,
   output logic                     clkLevel
);
   typedef struct packed {
      logic [LINK_W-1:0] d1;
      logic [LINK_W-1:0] d2;
      logic              c1;
      logic              c2;
      logic              c3;
      logic [LINK_W-1:0] cap;
      logic              vld;
   } smp_s;

   smp_s cur;
   smp_s next_cur;

   // First stages feed only the second; edge found on settled copies
   always_comb
   begin
      next_cur = cur;
      next_cur.d1 = linkData;
      next_cur.d2 = cur.d1;
      next_cur.c1 = linkClk;
      next_cur.c2 = cur.c1;
      next_cur.c3 = cur.c2;
      next_cur.vld = cur.c2 & ~cur.c3;
      // Data and clock share the same delay, so they stay aligned
      if (cur.c2 & ~cur.c3)
      begin
         next_cur.cap = cur.d2;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign capData  = cur.cap;
   assign capValid = cur.vld;
   assign clkLevel = cur.c3;
endmodule

// File: hw/pixel_port_formatter.sv
// Pixel port formatter: output layouts, receiver input, APB registers
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module pixel_port_formatter
   import pixel_port_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    srst,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [9:0]              vidCh1,
   input  wire logic [9:0]              vidCh2,
   input  wire logic [9:0]              vidCh3,
   input  wire logic                    vidHs,
   input  wire logic                    vidVs,
   input  wire logic                    vidField,
   input  wire logic                    vidDe,
   output logic                         sampleTake,
   input  wire logic [pixel_port_pkg::PIN_W-1:0] pixelIn,
   output logic      [pixel_port_pkg::PIN_W-1:0] pixelOut,
   output logic      [pixel_port_pkg::PIN_W-1:0] pixelOe,
   output logic                         pixClk,
   output logic                         hsOut,
   output logic                         vsOut,
   output logic                         fieldDeOut,
   input  wire logic                    rxClkPin,
   input  wire logic                    rxHsPin,
   input  wire logic                    rxVsPin,
   input  wire logic                    rxDePin,
   output logic      [9:0]              rxCh1,
   output logic      [9:0]              rxCh2,
   output logic      [9:0]              rxCh3,
   output logic                         rxHs,
   output logic                         rxVs,
   output logic                         rxDe,
   output logic                         rxValid
);
   typedef struct packed {
      logic [31:0]      ctrl;
      logic [15:0]      rxCount;
      logic [7:0]       divCnt;
      phase_e           phase;
      logic [29:0]      held;
      logic [PIN_W-1:0] pOut;
      logic [PIN_W-1:0] pOe;
      logic             pClk;
      logic             hs;
      logic             vs;
      logic             fd;
      logic             take;
      logic [9:0]       r1;
      logic [9:0]       r2;
      logic [9:0]       r3;
      logic             rhs;
      logic             rvs;
      logic             rde;
      logic             rvld;
      logic [31:0]      rdata;
      logic             rdy;
      logic             err;
   } fmt_s;

   fmt_s cur;
   fmt_s next_cur;

   logic [LINK_W-1:0] capData;
   logic              capValid;
   logic              linkLevel;

   // All link pins pass the two-stage synchroniser first
   rx_link_sampler rx_link_sampler_inst
   (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .linkClk  (rxClkPin),
      .linkData ({rxHsPin, rxVsPin, rxDePin, pixelIn}),
      .capData  (capData),
      .capValid (capValid),
      .clkLevel (linkLevel)
   );

   // Format actually used; receiver modes force 16-bit output
   function automatic out_fmt_e effFmt(input logic [2:0] f,
                                       input in_mode_e m);
      out_fmt_e r;
      r = out_fmt_e'(f);
      if (f > 3'(FMT_DDR12))
      begin
         r = FMT_SDR16;
      end
      if (m == IN_RX24 || m == IN_RX16)
      begin
         r = FMT_SDR16;
      end
      if (m == IN_TUNER && (r == FMT_SDR24 || r == FMT_SDR30 ||
                            r == FMT_DDR12))
      begin
         r = FMT_SDR16;
      end
      return r;
   endfunction

   // Place one word or one DDR half on the pins
   function automatic logic [PIN_W-1:0] mapOut(input out_fmt_e f,
                                               input logic half,
                                               input logic [29:0] s);
      logic [PIN_W-1:0] p;
      logic [9:0]       c1;
      logic [9:0]       c2;
      logic [9:0]       c3;
      logic [11:0]      w;
      p  = '0;
      c1 = s[29:20];
      c2 = s[19:10];
      c3 = s[9:0];
      // Two 12-bit halves carry only 24 of the 30 source bits, so 12-bit DDR drops c3 low bits
      w  = half ? {c2[7:0], c3[9:6]} : {c1, c2[9:8]};
      unique case (f)
         FMT_SDR16:
         begin
            p[19:12] = c1[9:2];
            p[9:2]   = c2[9:2];
         end
         FMT_SDR20:
         begin
            p[19:10] = c1;
            p[9:0]   = c2;
         end
         FMT_SDR24:
         begin
            p[19:12] = c1[9:2];
            p[9:2]   = c2[9:2];
            p[29:22] = c3[9:2];
         end
         FMT_SDR30:
         begin
            p[19:10] = c1;
            p[9:0]   = c2;
            p[29:20] = c3;
         end
         FMT_DDR8:
         begin
            p[19:12] = half ? c2[9:2] : c1[9:2];
         end
         FMT_DDR10:
         begin
            p[19:10] = half ? c2 : c1;
         end
         FMT_DDR12:
         begin
            p[19:12] = w[7:0];
            p[9:6]   = w[11:8];
         end
      endcase
      return p;
   endfunction

   // Pins driven in each mode; upper pins turn round for input
   function automatic logic [PIN_W-1:0] mapOe(input logic en,
                                              input in_mode_e m);
      logic [PIN_W-1:0] e;
      e = en ? {PIN_W{1'b1}} : '0;
      e[30] = 1'b0;
      if (m != IN_NONE)
      begin
         e[40:20] = '0;
      end
      if (m == IN_RX24)
      begin
         e[11:10] = 2'b00;
         e[1:0]   = 2'b00;
      end
      return e;
   endfunction

   in_mode_e  mode;
   out_fmt_e  fmt;
   logic      isDdr;
   logic      halfDone;
   logic      access;
   logic [29:0] fresh;

   assign mode     = in_mode_e'(cur.ctrl[INMODE_LSB +: 2]);
   assign fmt      = effFmt(cur.ctrl[FMT_LSB +: 3], mode);
   assign isDdr    = (fmt == FMT_DDR8 || fmt == FMT_DDR10 ||
                      fmt == FMT_DDR12);
   assign halfDone = (cur.divCnt == HALF_LAST);
   assign access   = psel & penable;
   assign fresh    = {vidCh1, vidCh2, vidCh3};

   // Next state: pixel clock, output word, receiver decode, registers
   always_comb
   begin
      next_cur = cur;
      next_cur.take = 1'b0;
      next_cur.rvld = 1'b0;
      next_cur.pOe  = mapOe(cur.ctrl[ENABLE_BIT], mode);
      next_cur.divCnt = halfDone ? 8'h00 : cur.divCnt + 8'h01;
      if (!cur.ctrl[ENABLE_BIT])
      begin
         next_cur.pClk   = 1'b0;
         next_cur.phase  = PH_FIRST;
         next_cur.divCnt = 8'h00;
      end
      else if (halfDone)
      begin
         unique case (cur.phase)
            PH_FIRST:
            begin
               // Rising edge: new pixel, timing launched with it
               next_cur.pClk  = 1'b1;
               next_cur.phase = PH_SECOND;
               next_cur.held  = fresh;
               next_cur.take  = 1'b1;
               next_cur.pOut  = mapOut(fmt, 1'b0, fresh);
               next_cur.hs    = vidHs;
               next_cur.vs    = vidVs;
               next_cur.fd    = cur.ctrl[DESEL_BIT] ? vidDe : vidField;
            end
            PH_SECOND:
            begin
               // Falling edge: second half of the same pixel
               next_cur.pClk  = 1'b0;
               next_cur.phase = PH_FIRST;
               if (isDdr)
               begin
                  next_cur.pOut = mapOut(fmt, 1'b1, cur.held);
               end
            end
         endcase
      end

      // Receiver and tuner words, unpacked per input mode
      if (capValid && mode != IN_NONE)
      begin
         next_cur.rvld    = 1'b1;
         next_cur.rxCount = cur.rxCount + 16'h0001;
         next_cur.rhs = capData[PIN_W + 2];
         next_cur.rvs = capData[PIN_W + 1];
         next_cur.rde = capData[PIN_W];
         next_cur.r2  = '0;
         next_cur.r3  = '0;
         unique case (mode)
            IN_TUNER:
            begin
               next_cur.r1 = capData[40:31];
            end
            IN_RX24:
            begin
               next_cur.r1 = {capData[40:33], 2'b00};
               next_cur.r2 = {capData[29:22], 2'b00};
               next_cur.r3 = {capData[32:31], capData[11:10],
                              capData[21:20], capData[1:0], 2'b00};
            end
            IN_RX16:
            begin
               next_cur.r1 = {capData[40:33], 2'b00};
               next_cur.r2 = {capData[32:31], capData[29:24], 2'b00};
            end
            default:
            begin
               next_cur.r1 = '0;
            end
         endcase
      end

      // APB: one wait state, then the access completes
      next_cur.rdy = access & ~cur.rdy;
      next_cur.err = 1'b0;
      if (access && !cur.rdy)
      begin
         next_cur.rdata = '0;
         unique case (paddr)
            CTRL_OFFSET:
            begin
               next_cur.rdata = cur.ctrl;
            end
            STATUS_OFFSET:
            begin
               next_cur.rdata[ST_PHASE_BIT] = cur.pClk;
               next_cur.rdata[ST_CLK_BIT]   = linkLevel;
               next_cur.rdata[ST_FMT_LSB +: 3] = fmt;
            end
            RXCNT_OFFSET:
            begin
               next_cur.rdata[15:0] = cur.rxCount;
            end
            default:
            begin
               next_cur.err = 1'b1;
            end
         endcase
      end
      // Writes land on the completing edge only
      if (access && cur.rdy && pwrite)
      begin
         if (paddr == CTRL_OFFSET)
         begin
            next_cur.ctrl = {24'h000000, pwdata[7:0]};
         end
         else if (paddr == RXCNT_OFFSET)
         begin
            next_cur.rxCount = {15'h0000, next_cur.rvld}; // Capture wins
         end
      end
      next_cur.err = next_cur.err & ~pwrite | (access & ~cur.rdy &
                     ~(paddr == CTRL_OFFSET || paddr == STATUS_OFFSET ||
                       paddr == RXCNT_OFFSET));
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cur      <= '0;
         cur.ctrl <= CTRL_RESET;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // Every output straight from the state register
   assign prdata     = cur.rdata;
   assign pready     = cur.rdy;
   assign pslverr    = cur.err;
   assign sampleTake = cur.take;
   assign pixelOut   = cur.pOut;
   assign pixelOe    = cur.pOe;
   assign pixClk     = cur.pClk;
   assign hsOut      = cur.hs;
   assign vsOut      = cur.vs;
   assign fieldDeOut = cur.fd;
   assign rxCh1      = cur.r1;
   assign rxCh2      = cur.r2;
   assign rxCh3      = cur.r3;
   assign rxHs       = cur.rhs;
   assign rxVs       = cur.rvs;
   assign rxDe       = cur.rde;
   assign rxValid    = cur.rvld;
endmodule

// File: bench/pixel_port_formatter_sva.sv
// Port checker for the pixel port formatter
`timescale 1ns/1ps
module pixel_port_formatter_sva
   import pixel_port_pkg::*;
(
   input wire logic               ref_clk,
   input wire logic               srst,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               pixClk,
   input wire logic               sampleTake,
   input wire logic [PIN_W-1:0]   pixelOut,
   input wire logic               hsOut,
   input wire logic               rxClkPin,
   input wire logic               rxValid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Slave answers after exactly one wait cycle
   property p_ready_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("late pready");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
   property p_err_qual;
      pslverr |-> pready;
   endproperty
   a_err_qual: assert property (p_err_qual) else $error("stray pslverr");
   // Two cycles high, two low, no drift
   property p_clk_shape;
      $rose(pixClk) |=> pixClk ##1 !pixClk [*2] ##1 pixClk;
   endproperty
   a_clk_shape: assert property (p_clk_shape)
      else $error("pixClk shape");
   property p_take;
      $rose(pixClk) |-> sampleTake;
   endproperty
   a_take: assert property (p_take) else $error("no sample taken");
   // Data moves only with a pixel clock edge
   property p_hold;
      $changed(pixelOut) |-> $changed(pixClk);
   endproperty
   a_hold: assert property (p_hold) else $error("data off edge");
   property p_sync;
      $changed(hsOut) |-> $rose(pixClk);
   endproperty
   a_sync: assert property (p_sync) else $error("hsync off edge");
   // Capture follows a link clock that stood high
   property p_rx_lat;
      rxValid |-> $past(rxClkPin, 2) && $past(rxClkPin, 3);
   endproperty
   a_rx_lat: assert property (p_rx_lat) else $error("rx latency");
endmodule

// File: bench/rx_link_model.sv
// Behavioural digital receiver on the pixel port input pins
`timescale 1ns/1ps
module rx_link_model
(
   input  wire logic   run,
   output logic        linkClk,
   output logic [40:0] pins,
   output logic [2:0]  tim,
   output logic [40:0] seenPins,
   output logic [2:0]  seenTim,
   output int          sent
);
   logic [31:0] seq;
   // Clock only inside bursts; data moves on the falling edge for margin
   initial
   begin
      linkClk = 0;
      pins = '0;
      tim = '0;
      seq = '0;
      sent = 0;
      #13;
      forever
      begin
         if (run)
         begin
            #200 linkClk = 1;
            seenPins = pins;
            seenTim = tim;
            #200 linkClk = 0;
            sent++;
            seq = seq + 32'h1;
            pins = {seq[8:0], seq * 32'h9E37_79B9};
            tim = seq[2:0];
         end
         else
         begin
            #50 pins = ~pins; // Idle lines never show a stale value
            tim = ~tim;
         end
      end
   end
endmodule

// File: bench/pixel_port_formatter_tb.sv
// Self-checking bench for the pixel port formatter
`timescale 1ns/1ps
module pixel_port_formatter_tb;
   import pixel_port_pkg::*;
   logic             ref_clk = 0, srst = 1, psel = 0, penable = 0;
   logic             pwrite = 0, vidHs = 0, vidDe = 0, runLink = 0, err;
   logic             vidVs = 0, vidField = 0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata, rd;
   logic [9:0]       vidCh1 = 0, vidCh2 = 0, vidCh3 = 0, rxCh1, rxCh2, rxCh3;
   logic             pready, pslverr, sampleTake, pixClk, hsOut, vsOut;
   logic             fieldDeOut, rxClkPin, rxHs, rxVs, rxDe, rxValid;
   logic [PIN_W-1:0] pixelIn, pixelOut, pixelOe, drv, seenPins, m;
   logic [2:0]       tim, seenTim;
   logic [29:0]      rm;
   int               miscompares = 0, compares = 0, sent, base, n;
   always #25 ref_clk = ~ref_clk;
   // Wire level from the formatter's enables: its pins where driven, the model elsewhere
   assign pixelIn = (pixelOe & pixelOut) | (~pixelOe & drv);
   pixel_port_formatter pixel_port_formatter_inst (.ref_clk, .srst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .vidCh1, .vidCh2, .vidCh3, .vidHs, .vidVs, .vidField,
      .vidDe, .sampleTake, .pixelIn, .pixelOut, .pixelOe, .pixClk, .hsOut,
      .vsOut, .fieldDeOut, .rxClkPin, .rxHsPin(tim[2]), .rxVsPin(tim[1]),
      .rxDePin(tim[0]), .rxCh1, .rxCh2, .rxCh3, .rxHs, .rxVs, .rxDe,
      .rxValid);
   rx_link_model rx_link_model_inst (.run(runLink), .linkClk(rxClkPin),
      .pins(drv), .tim(tim), .seenPins(seenPins), .seenTim(seenTim),
      .sent(sent));
   task automatic conclude();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [40:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic hang(input int lim);
      if (n >= lim)
      begin
         miscompares++;
         conclude();
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      hang(20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Bounded wait for a take (0) or a capture (1)
   task automatic waitFor(input bit which);
      n = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end while ((which ? rxValid : sampleTake) !== 1'b1 && n < 80);
      hang(80);
   endtask
   function automatic logic [40:0] expf(input int f, input logic h,
                                        input logic [9:0] a, b, c);
      logic [40:0] o;
      o = '0;
      case (f)
         0, 7: {o[19:12], o[9:2]} = {a[9:2], b[9:2]};
         1: {o[19:10], o[9:0]} = {a, b};
         2: {o[19:12], o[9:2], o[29:22]} = {a[9:2], b[9:2], c[9:2]};
         3: {o[19:10], o[9:0], o[29:20]} = {a, b, c};
         4: o[19:12] = h ? b[9:2] : a[9:2];
         5: o[19:10] = h ? b : a;
         default: {o[9:6], o[19:12]} = h ? {b[7:0], c[9:6]} : {a, b[9:8]};
      endcase
      return o;
   endfunction
   function automatic logic [29:0] rxExp(input int md, input logic [40:0] p);
      case (md)
         1: return {p[40:31], 20'h0};
         2: return {p[40:33], 2'h0, p[29:22], 2'h0, p[32:31], p[11:10],
                    p[21:20], p[1:0], 2'h0};
         default: return {p[40:33], 2'h0, p[32:31], p[29:24], 12'h0};
      endcase
   endfunction
   initial
   begin
      repeat (12) @(posedge ref_clk);
      srst <= 0;
      // Reset values, unmapped access, dropped upper bits
      apb(0, CTRL_OFFSET, 0);
      chk("ctrl", rd, CTRL_RESET);
      apb(0, RXCNT_OFFSET, 0);
      chk("rxcnt", rd, 0);
      apb(1, 8'h0C, 32'hFFFF_FFFF);
      chk("wr err", err, 1);
      apb(0, 8'h0C, 0);
      chk("rd err", {err, rd}, 33'h1_0000_0000);
      apb(1, CTRL_OFFSET, 32'hFFFF_FF00);
      apb(0, CTRL_OFFSET, 0);
      chk("ctrl bits", rd, 0);
      chk("idle clk", pixClk, 0);
      // Every output layout, both halves of a pixel
      for (int f = 0; f < 8; f++)
      begin
         @(posedge ref_clk);
         vidCh1 <= 10'h3A5 ^ 10'(f);
         vidCh2 <= 10'h1C6 + 10'(f);
         vidCh3 <= 10'h2B9 - 10'(f);
         vidHs <= f[0];
         vidVs <= ~f[0];
         vidField <= f[1];
         vidDe <= ~f[1];
         // Bit 6 picks data enable over field for the upper formats
         apb(1, CTRL_OFFSET, 32'h0000_0080 | 32'(f) | {25'h0, f[2], 6'h00});
         waitFor(0);
         waitFor(0);
         m = expf(f, 0, 10'h3FF, 10'h3FF, 10'h3FF);
         chk("half1", pixelOut & m, expf(f, 0, vidCh1, vidCh2, vidCh3));
         chk("hs", hsOut, vidHs);
         chk("vs", vsOut, vidVs);
         chk("de", fieldDeOut, f[2] ? vidDe : vidField);
         chk("oe", pixelOe, 41'h1FF_BFFF_FFFF);
         repeat (2) @(posedge ref_clk);
         #1;
         chk("clk low", pixClk, 0);
         chk("half2", pixelOut & m, expf(f, f > 3 && f < 7, vidCh1, vidCh2,
             vidCh3));
         apb(0, STATUS_OFFSET, 0);
         chk("fmt", rd[6:4], f == 7 ? 0 : f);
      end
      // Tuner and both receiver input modes
      for (int md = 1; md < 4; md++)
      begin
         apb(1, CTRL_OFFSET, 32'h0000_0083 | 32'(md << 4));
         apb(1, RXCNT_OFFSET, 32'h0);
         apb(0, STATUS_OFFSET, 0);
         chk("forced fmt", rd[6:4], 0);
         base = sent;
         runLink <= 1;
         for (int k = 0; k < 3; k++)
         begin
            waitFor(1);
            rm = {rxCh1, rxCh2, rxCh3};
            chk("rx words", rm, rxExp(md, seenPins));
            chk("rx timing", {rxHs, rxVs, rxDe}, seenTim);
         end
         @(posedge ref_clk);
         runLink <= 0;
         repeat (30) @(posedge ref_clk);
         apb(0, RXCNT_OFFSET, 0);
         chk("rx count", rd, sent - base);
         chk("in pins", pixelOe[40:20], 0);
         chk("low pins", {pixelOe[11:10], pixelOe[1:0]},
             md == 2 ? 0 : 15);
      end
      conclude();
   end
endmodule
bind pixel_port_formatter pixel_port_formatter_sva
   pixel_port_formatter_sva_inst
   (.ref_clk, .srst, .psel, .penable, .pready, .pslverr, .pixClk,
    .sampleTake, .pixelOut, .hsOut, .rxClkPin, .rxValid);
